/* File: rtl/fevp_top.sv */
// Flash erase-verify sequencer and program/erase protection with AHB-Lite registers
`timescale 1ns/1ps

module fevp_top
  import fevp_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // System protection inputs
  input  wire logic                 flash_write_enable_pin,
  input  wire logic                 watchdog_reset,
  input  wire logic                 standby,
  input  wire fevp_err_evt_t        err_evt,
  // Flash array side
  input  wire logic [15:0]          flash_rdata,
  output logic [DUMMY_AW-1:0]       flash_addr,
  output fevp_mode_t                flash_mode,
  output logic [15:0]               erase_block_en,
  // Watchdog guard
  output logic                      watchdog_guard_clear
);

  // ****************************************
  // State
  // ****************************************
  fevp_ctrl_one_t      ctrl_one_q, ctrl_one_d;
  logic [7:0]          blksel_one_q, blksel_one_d;
  logic [7:0]          blksel_two_q, blksel_two_d;
  logic                ram_sel_q;
  logic [2:0]          ram_rgn_q;
  logic                err_q, err_d;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic                dummy_ok_q;
  fevp_mode_t          mode_q, mode_d;
  logic [15:0]         blk_en_q, blk_en_d;
  logic [DUMMY_AW-1:0] faddr_q;
  logic [31:0]         hrdata_q;
  logic                hreadyout_q;
  logic                hresp_q;
  logic                wdt_clr_q;
  logic [TMR_W-1:0]    elapsed;
  logic                tmr_restart;
  logic                hw_clear;
  logic                dummy_acc;
  logic                addr_phase;

  // Wait is met once the counter reaches the least cycle count
  function automatic logic wait_met(input logic [TMR_W-1:0] el,
                                    input logic [TMR_W-1:0] need);
    return el >= need;
  endfunction

  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    return pend && (a == ofs);
  endfunction

  // ****************************************
  // Bus address phase
  // ****************************************
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  // Resets of the sequence without the pin reset
  assign hw_clear   = watchdog_reset || standby;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // ****************************************
  // Control register one and block selects
  // ****************************************
  always_comb begin
    ctrl_one_d   = ctrl_one_q;
    blksel_one_d = blksel_one_q;
    blksel_two_d = blksel_two_q;
    if (wr_hit(wr_pend_q, wr_addr_q, OFS_CTRL_ONE)) begin
      ctrl_one_d.software_write_enable_bit = hwdata[6];
      ctrl_one_d.psu = hwdata[4];
      ctrl_one_d.ev  = hwdata[3];
      ctrl_one_d.pv  = hwdata[2];
      ctrl_one_d.p   = hwdata[0];
      // Erase pulse only after erase setup has settled
      if (hwdata[1] && !ctrl_one_q.e) begin
        ctrl_one_d.e = ctrl_one_q.erase_setup_bit && wait_met(elapsed, SESU_CYC);
      end else begin
        ctrl_one_d.e = hwdata[1];
      end
      // Erase setup held until the pulse is off for the hold time
      if (!hwdata[5] && ctrl_one_q.erase_setup_bit) begin
        ctrl_one_d.erase_setup_bit = !(!ctrl_one_q.e && !hwdata[1] && wait_met(elapsed, CE_CYC));
      end else begin
        ctrl_one_d.erase_setup_bit = hwdata[5];
      end
    end
    if (wr_hit(wr_pend_q, wr_addr_q, OFS_BLKSEL_ONE)) begin
      blksel_one_d = hwdata[7:0];
    end
    if (wr_hit(wr_pend_q, wr_addr_q, OFS_BLKSEL_TWO)) begin
      blksel_two_d = hwdata[7:0];
    end
    if (!ctrl_one_d.software_write_enable_bit) begin
      ctrl_one_d.p = 1'b0;
      ctrl_one_d.e = 1'b0;
    end
    if (!flash_write_enable_pin || hw_clear) begin
      ctrl_one_d   = CTRL_ONE_RESET;
      blksel_one_d = BLKSEL_RESET;
      blksel_two_d = BLKSEL_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_q   <= CTRL_ONE_RESET;
      blksel_one_q <= BLKSEL_RESET;
      blksel_two_q <= BLKSEL_RESET;
    end else begin
      ctrl_one_q   <= ctrl_one_d;
      blksel_one_q <= blksel_one_d;
      blksel_two_q <= blksel_two_d;
    end
  end

  // ****************************************
  // RAM overlay control
  // ****************************************
  // Overlay setting is not part of the flash reset group
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_sel_q <= 1'b0;
      ram_rgn_q <= RAM_RGN_RESET;
    end else if (wr_hit(wr_pend_q, wr_addr_q, OFS_RAM_OVL)) begin
      ram_sel_q <= hwdata[RAM_SEL_POS];
      ram_rgn_q <= hwdata[2:0];
    end
  end

  // ****************************************
  // Error protection
  // ****************************************
  always_comb begin
    err_d = err_q;
    if (hw_clear) begin
      err_d = 1'b0;
    end
    // Only an active program or erase can raise the flag
    if ((mode_q.prog_mode || mode_q.erase_mode) && (err_evt != '0)) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else begin
      err_q <= err_d;
    end
  end

  // ****************************************
  // Operating modes and block enables
  // ****************************************
  always_comb begin
    mode_d.prog_mode  = ctrl_one_d.p && ctrl_one_d.psu && !err_d && !ram_sel_q;
    mode_d.erase_mode = ctrl_one_d.e && ctrl_one_d.erase_setup_bit && !err_d && !ram_sel_q
                        && ({blksel_two_d, blksel_one_d} != 16'h0000);
    // Verify survives error and emulation protection, not a low pin
    mode_d.prog_verify  = ctrl_one_d.pv && flash_write_enable_pin;
    mode_d.erase_verify = ctrl_one_d.ev && flash_write_enable_pin;
    blk_en_d = mode_d.erase_mode ? {blksel_two_d, blksel_one_d} : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= '0;
      blk_en_q <= 16'h0000;
    end else begin
      mode_q   <= mode_d;
      blk_en_q <= blk_en_d;
    end
  end

  // Leaving erase setup drops the overerase watchdog setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= ctrl_one_q.erase_setup_bit && !ctrl_one_d.erase_setup_bit;
    end
  end

  // ****************************************
  // Wait timing and dummy write
  // ****************************************
  assign dummy_acc = wr_hit(wr_pend_q, wr_addr_q, OFS_DUMMY_WR)
                     && (mode_q.erase_verify || mode_q.prog_verify)
                     && (hwdata[7:0] == DUMMY_DATA)
                     && wait_met(elapsed, SEV_CYC);

  assign tmr_restart = dummy_acc
                       || (ctrl_one_d.e != ctrl_one_q.e)
                       || (ctrl_one_d.erase_setup_bit != ctrl_one_q.erase_setup_bit)
                       || (ctrl_one_d.ev != ctrl_one_q.ev)
                       || (ctrl_one_d.pv != ctrl_one_q.pv);

  fevp_wait_timer u_timer (
    .clk       (clk),
    .rst_n     (rst_n),
    .restart   (tmr_restart),
    .elapsed_q (elapsed)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faddr_q    <= '0;
      dummy_ok_q <= 1'b0;
    end else if (dummy_acc) begin
      faddr_q    <= hwdata[DUMMY_AW_LSB +: DUMMY_AW];
      dummy_ok_q <= 1'b1;
    end else if (!mode_d.erase_verify && !mode_d.prog_verify) begin
      dummy_ok_q <= 1'b0;
    end
  end

  // ****************************************
  // Bus read data and response
  // ****************************************
  // Control, error and block select reads use next-state values so a read after a write sees it; RAM overlay and status use registered values, bar the pin bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      if (haddr[7:0] == OFS_CTRL_ONE) begin
        hrdata_q <= {25'h0, ctrl_one_d};
      end else if (haddr[7:0] == OFS_CTRL_TWO) begin
        hrdata_q <= {24'h0, err_d, 7'h00};
      end else if (haddr[7:0] == OFS_BLKSEL_ONE) begin
        hrdata_q <= {24'h0, blksel_one_d};
      end else if (haddr[7:0] == OFS_BLKSEL_TWO) begin
        hrdata_q <= {24'h0, blksel_two_d};
      end else if (haddr[7:0] == OFS_RAM_OVL) begin
        hrdata_q <= {28'h0, ram_sel_q, ram_rgn_q};
      end else if (haddr[7:0] == OFS_STATUS) begin
        hrdata_q <= {25'h0, dummy_ok_q, err_q, !flash_write_enable_pin, mode_q};
      end else if (haddr[7:0] == OFS_VERIFY_RD) begin
        // Early or unarmed verify reads return zero, never stale array data
        if (dummy_ok_q && !tmr_restart && wait_met(elapsed, SEVR_CYC)) begin
          hrdata_q <= {16'h0000, flash_rdata};
        end else begin
          hrdata_q <= 32'h0000_0000;
        end
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b0;
      hresp_q     <= HRESP_OKAY;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= HRESP_OKAY;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hrdata               = hrdata_q;
  assign hreadyout            = hreadyout_q;
  assign hresp                = hresp_q;
  assign flash_addr           = faddr_q;
  assign flash_mode           = mode_q;
  assign erase_block_en       = blk_en_q;
  assign watchdog_guard_clear = wdt_clr_q;

endmodule

/* File: rtl/fevp_pkg.sv */
// Constants, register map and carrier types of the flash erase-verify protection block
package fevp_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_BLKSEL_ONE = 8'h08;
  localparam logic [7:0] OFS_BLKSEL_TWO = 8'h0C;
  localparam logic [7:0] OFS_RAM_OVL    = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_DUMMY_WR   = 8'h18;
  localparam logic [7:0] OFS_VERIFY_RD  = 8'h1C;

  localparam int unsigned ERR_FLAG_POS  = 7;
  localparam int unsigned RAM_SEL_POS   = 3;
  localparam int unsigned DUMMY_AW      = 24;
  localparam int unsigned DUMMY_AW_LSB  = 8;
  localparam logic [7:0]  DUMMY_DATA    = 8'hFF;
  localparam logic [7:0]  BLKSEL_RESET  = 8'h00;
  localparam logic [2:0]  RAM_RGN_RESET = 3'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  // ****************************************
  // Minimum wait times
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_SESU_NS     = 1000;
  localparam int unsigned T_CE_NS       = 1000;
  localparam int unsigned T_SEV_NS      = 1000;
  localparam int unsigned T_SEVR_NS     = 1000;
  localparam int unsigned TMR_W         = 10;

  // Least times round up to whole cycles
  function automatic logic [TMR_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return c[TMR_W-1:0];
  endfunction

  localparam logic [TMR_W-1:0] SESU_CYC = ns_to_cyc(T_SESU_NS);
  localparam logic [TMR_W-1:0] CE_CYC   = ns_to_cyc(T_CE_NS);
  localparam logic [TMR_W-1:0] SEV_CYC  = ns_to_cyc(T_SEV_NS);
  localparam logic [TMR_W-1:0] SEVR_CYC = ns_to_cyc(T_SEVR_NS);

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic software_write_enable_bit;
    logic erase_setup_bit;
    logic psu;
    logic ev;
    logic pv;
    logic e;
    logic p;
  } fevp_ctrl_one_t;

  localparam fevp_ctrl_one_t CTRL_ONE_RESET = '0;

  typedef struct packed {
    logic erase_verify;
    logic prog_verify;
    logic erase_mode;
    logic prog_mode;
  } fevp_mode_t;

  typedef struct packed {
    logic bus_release;
    logic sleep_exec;
    logic exception_start;
    logic flash_read;
  } fevp_err_evt_t;

endpackage

/* File: rtl/fevp_wait_timer.sv */
// Saturating cycle counter that measures time since the last sequence event
`timescale 1ns/1ps
module fevp_wait_timer
  import fevp_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             restart,
  // Elapsed cycles
  output logic [TMR_W-1:0]      elapsed_q
);

  // ****************************************
  // Counter
  // ****************************************
  // Saturation keeps a long wait from wrapping back below a threshold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_q <= '0;
    end else if (restart) begin
      elapsed_q <= '0;
    end else if (elapsed_q != '1) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

endmodule

/* File: bench/fevp_top_props.sv */
// Concurrent checks on the ports of the flash erase-verify protection block
`timescale 1ns/1ps
module fevp_top_props
  import fevp_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Protection inputs
  input wire logic          flash_write_enable_pin,
  input wire logic          watchdog_reset,
  input wire logic          standby,
  input wire fevp_err_evt_t err_evt,
  // Flash side
  input wire fevp_mode_t    flash_mode,
  input wire logic [15:0]   erase_block_en,
  input wire logic          watchdog_guard_clear
);
  logic err_seen_q;
  logic busy;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  assign busy = flash_mode.erase_mode || flash_mode.prog_mode;

  // Mirror of the error state, kept only until a watchdog reset or standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_seen_q <= 1'b0;
    end else if (watchdog_reset || standby) begin
      err_seen_q <= 1'b0;
    end else if (busy && (err_evt != 4'h0)) begin
      err_seen_q <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  chk_blk_en_mode: assert property ((erase_block_en != 16'h0000) == flash_mode.erase_mode)
    else $error("block enables disagree with erase mode");
  chk_pin_low_idle: assert property (
    (!flash_write_enable_pin ##1 !flash_write_enable_pin) |-> (flash_mode == 4'h0))
    else $error("mode active with write enable pin low");
  chk_wdt_clears: assert property (
    watchdog_reset |-> ##2 (!busy && erase_block_en == 16'h0000))
    else $error("watchdog reset left a mode active");
  chk_standby_clears: assert property (standby |-> ##2 !busy)
    else $error("standby left a mode active");
  chk_err_aborts: assert property ((busy && err_evt != 4'h0) |=> !busy)
    else $error("error event did not abort operation");
  chk_err_no_restart: assert property (err_seen_q |-> !busy)
    else $error("mode re-entered in error protection");
  chk_guard_pulse: assert property (watchdog_guard_clear |=> !watchdog_guard_clear)
    else $error("guard clear longer than one cycle");
  chk_guard_exit: assert property (watchdog_guard_clear |-> !flash_mode.erase_mode)
    else $error("guard cleared while still erasing");
endmodule

bind fevp_top fevp_top_props fevp_top_props_inst (
  .clk                    (clk),
  .rst_n                  (rst_n),
  .flash_write_enable_pin (flash_write_enable_pin),
  .watchdog_reset         (watchdog_reset),
  .standby                (standby),
  .err_evt                (err_evt),
  .flash_mode             (flash_mode),
  .erase_block_en         (erase_block_en),
  .watchdog_guard_clear   (watchdog_guard_clear)
);

/* File: bench/fevp_top_bench.sv */
// Directed bench for the flash erase-verify protection block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module fevp_top_bench
  import fevp_pkg::*;
;
  logic                clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                pin_hi, dog_rst, standby, guard, guard_seen;
  fevp_err_evt_t       err_evt;
  fevp_mode_t          flash_mode;
  logic [15:0]         flash_rdata, erase_block_en;
  logic [DUMMY_AW-1:0] flash_addr;
  int                  errors, checks_done;
  logic [7:0]          offs [7] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_BLKSEL_ONE,
                                    OFS_BLKSEL_TWO, OFS_STATUS, OFS_VERIFY_RD, 8'h20};

  fevp_top fevp_top_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_write_enable_pin(pin_hi), .watchdog_reset(dog_rst), .standby(standby),
    .err_evt(err_evt), .flash_rdata(flash_rdata), .flash_addr(flash_addr),
    .flash_mode(flash_mode), .erase_block_en(erase_block_en), .watchdog_guard_clear(guard));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Array model: data derived from the latched address, so a wrong address shows
  always @(posedge clk) flash_rdata <= flash_addr[15:0] ^ 16'h5A5A;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) guard_seen <= 1'b0;
    else if (guard === 1'b1) guard_seen <= 1'b1;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic phase_wait;
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      if (n == 50) begin
        errors++;
        $display("[FAIL] hreadyout exp 1 got %b", hreadyout);
        finish_test();
      end
      n++;
      @(negedge clk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    phase_wait();
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    phase_wait();
    `CHK("hresp", HRESP_OKAY, hresp)
    @(posedge clk);
    q = hrdata;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK($sformatf("reg %h", a), e, q)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Setup bit, then the pulse bit once the 40 cycle least wait is over
  task automatic arm(input logic [31:0] setup, input logic [31:0] pulse);
    wr(OFS_CTRL_ONE, setup);
    idle(45);
    wr(OFS_CTRL_ONE, pulse);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, hsel, hwrite, dog_rst, standby} = '0;
    {haddr, hwdata, htrans, err_evt} = '0;
    hsize = 3'h2;
    pin_hi = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    foreach (offs[i]) rchk(offs[i], 32'h0);
    $display("test reset_values done");
    wr(OFS_BLKSEL_TWO, 32'h80);
    wr(OFS_CTRL_ONE, 32'h60);
    wr(OFS_CTRL_ONE, 32'h62);
    rchk(OFS_CTRL_ONE, 32'h60);
    idle(45);
    wr(OFS_CTRL_ONE, 32'h62);
    `CHK("erase_mode", 1'b1, flash_mode.erase_mode)
    `CHK("block_en", 16'h8000, erase_block_en)
    arm(32'h60, 32'h40);
    idle(2);
    `CHK("guard", 1'b1, guard_seen)
    wr(OFS_CTRL_ONE, 32'h48);
    `CHK("verify", 1'b1, flash_mode.erase_verify)
    idle(45);
    wr(OFS_DUMMY_WR, 32'h000100FF);
    `CHK("addr", 24'h000100, flash_addr)
    rchk(OFS_VERIFY_RD, 32'h0);
    idle(45);
    rchk(OFS_VERIFY_RD, 32'h00005B5A);
    wr(OFS_DUMMY_WR, 32'h00020000);
    `CHK("addr", 24'h000100, flash_addr)
    wr(OFS_DUMMY_WR, 32'h000101FF);
    `CHK("addr", 24'h000101, flash_addr)
    idle(45);
    rchk(OFS_VERIFY_RD, 32'h00005B5B);
    wr(OFS_CTRL_ONE, 32'h40);
    idle(45);
    $display("test erase_verify done");
    wr(OFS_BLKSEL_TWO, 32'h0);
    arm(32'h60, 32'h62);
    `CHK("erase_mode", 1'b0, flash_mode.erase_mode)
    `CHK("block_en", 16'h0, erase_block_en)
    rchk(OFS_CTRL_ONE, 32'h62);
    arm(32'h60, 32'h40);
    wr(OFS_RAM_OVL, 32'h08);
    arm(32'h50, 32'h51);
    `CHK("prog_mode", 1'b0, flash_mode.prog_mode)
    wr(OFS_RAM_OVL, 32'h0);
    // Modes follow the overlay register one cycle later
    idle(1);
    `CHK("prog_mode", 1'b1, flash_mode.prog_mode)
    $display("test software_protect done");
    for (int i = 0; i < 4; i++) begin
      if (i > 0) arm(32'h50, 32'h51);
      @(posedge clk);
      err_evt <= fevp_err_evt_t'(4'h1 << i);
      @(posedge clk);
      err_evt <= '0;
      idle(2);
      `CHK("prog_mode", 1'b0, flash_mode.prog_mode)
      rchk(OFS_CTRL_TWO, 32'h80);
      rchk(OFS_CTRL_ONE, 32'h51);
      wr(OFS_CTRL_ONE, 32'h55);
      `CHK("prog_verify", 1'b1, flash_mode.prog_verify)
      @(posedge clk);
      if (i[0]) standby <= 1'b1;
      else dog_rst <= 1'b1;
      @(posedge clk);
      standby <= 1'b0;
      dog_rst <= 1'b0;
      idle(1);
      rchk(OFS_CTRL_TWO, 32'h0);
      rchk(OFS_CTRL_ONE, 32'h0);
    end
    $display("test error_protect done");
    wr(OFS_BLKSEL_ONE, 32'h01);
    wr(OFS_CTRL_ONE, 32'h60);
    @(posedge clk);
    pin_hi <= 1'b0;
    idle(3);
    rchk(OFS_CTRL_ONE, 32'h0);
    rchk(OFS_BLKSEL_ONE, 32'h0);
    rchk(OFS_STATUS, 32'h10);
    @(posedge clk);
    pin_hi <= 1'b1;
    $display("test pin_protect done");
    arm(32'h50, 32'h51);
    `CHK("prog_mode", 1'b1, flash_mode.prog_mode)
    @(posedge clk);
    dog_rst <= 1'b1;
    @(posedge clk);
    dog_rst <= 1'b0;
    idle(1);
    `CHK("prog_mode", 1'b0, flash_mode.prog_mode)
    $display("test watchdog_abort done");
    wr(OFS_BLKSEL_ONE, 32'h05);
    wr(OFS_CTRL_ONE, 32'h40);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    rchk(OFS_BLKSEL_ONE, 32'h0);
    rchk(OFS_CTRL_ONE, 32'h0);
    $display("test mid_reset done");
    finish_test();
  end
endmodule
